// *** src/prsd_pkg.sv ***
/*
 * constants for the pll reference select and divide block: register map,
 * field positions, reset values, monitor codes and the loss timeout.
 * assumes a 50 MHz ref_clk and a byte-wide register port.
 */
package prsd_pkg;
    // ********************************
    // register map
    // ********************************
    localparam logic [9:0] ADDR_RDIV_LOW  = 10'h011;
    localparam logic [9:0] ADDR_RDIV_HIGH = 10'h012;
    localparam logic [9:0] ADDR_BIAS_CTRL = 10'h018;
    localparam logic [9:0] ADDR_MON_CTRL  = 10'h01b;
    localparam logic [9:0] ADDR_SEL_CTRL  = 10'h01c;
    localparam logic [7:0] RST_VAL_8      = 8'h00;
    // ref_input_bias_ctrl fields
    localparam int BIAS_R_RESET   = 0;
    localparam int BIAS_SHARE_RST = 1;
    localparam int BIAS_XTAL_EN   = 6;
    localparam int BIAS_DC_OFFSET = 7;
    // ref_select_ctrl fields
    localparam int SEL_DIFF       = 0;
    localparam int SEL_FIRST_ON   = 1;
    localparam int SEL_SECOND_ON  = 2;
    localparam int SEL_MAN_SECOND = 3;
    localparam int SEL_USE_PIN    = 4;
    localparam int SEL_AUTO       = 5;
    localparam int SEL_PREF_SEC   = 6;
    localparam int SEL_DEGL_DIS   = 7;
    // ref_monitor_ctrl fields; bits 7:4 read back live state
    localparam int MON_SRC_LSB    = 0;
    localparam int MON_USE_STATUS = 3;
    localparam logic [2:0] MON_FIRST_BAD  = 3'h7;
    localparam logic [2:0] MON_SECOND_BAD = 3'h6;
    localparam logic [2:0] MON_HIGH       = 3'h1;
    // ********************************
    // timing
    // ********************************
    localparam int CLK_PERIOD_NS  = 20;
    localparam int REF_TIMEOUT_NS = 1000;
    localparam logic [7:0] REF_TIMEOUT_CYC =
        8'(REF_TIMEOUT_NS / CLK_PERIOD_NS);
    localparam int RDIV_W = 14;
endpackage

// *** src/prsd_ref_path.sv ***
/*
 * reference input enables, switchover with deglitch, loss monitor and the
 * 14-bit reference divider feeding the phase-frequency detector.
 * assumes reference and pin inputs are synchronous to ref_clk and that a
 * serial-port front end drives the byte register port.
 */
// Operation
// - every reference input is off after power-up until enabled
// - reference select register chooses differential or single-ended type
// - offset bit lowers single-ended bias so stopped inputs do not chatter
// - each single-ended buffer has its own power-down control
// - differential receiver off unless selected and pll powered up
// - single-ended buffer off on pll power-down or its own power-down
// - differential type forces both single-ended buffers off
// - crystal enable bit turns on the maintaining amplifier
// - switching between references only in dual single-ended mode
// - manual switchover from register bit or reference-choose pin
// - monitor high while first reference invalid, then second selected
// - revertive: monitor drops and first reference used again when valid
// - status input may drive auto switch; second may be preferred
// - deglitch blocks misaligned edges until new reference edge arrives
// - a control bit disables the switchover deglitch
// - no nonrevertive automatic mode; always returns to preferred
// - 14-bit divider ratio written over two register addresses
// - ratio zero or one divides by one
// - divided reference drives the phase-frequency detector input
// - divider reset by own bit, shared counter bit or sync
`timescale 1ns/100ps
`default_nettype none
module prsd_ref_path
    import prsd_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // register port
    input  wire logic [9:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_we,
    input  wire logic       reg_re,
    output logic      [7:0] reg_rdata,
    // reference pins and system controls
    input  wire logic       first_reference,
    input  wire logic       second_reference,
    input  wire logic       ref_choose_pin,
    input  wire logic       status_in,
    input  wire logic       pll_power_down,
    input  wire logic       sync_pulse,
    // analog controls and monitor
    output logic            diff_rx_pd,
    output logic            first_ref_pd,
    output logic            second_ref_pd,
    output logic            dc_offset_en,
    output logic            crystal_amp_enable,
    output logic            ref_loss_monitor_out,
    output logic            second_active,
    // to phase-frequency detector
    output logic            pfd_ref_out
);
    typedef enum logic [1:0] {
        DG_PASS = 2'b01,
        DG_WAIT = 2'b10
    } prsd_dg_t;

    // ********************************
    // registers
    // ********************************
    logic [7:0] rdiv_low_reg;
    logic [7:0] rdiv_high_reg;
    logic [7:0] bias_reg;
    logic [7:0] mon_reg;
    logic [7:0] sel_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rdiv_low_reg  <= RST_VAL_8;
            rdiv_high_reg <= RST_VAL_8;
            bias_reg      <= RST_VAL_8;
            mon_reg       <= RST_VAL_8;
            sel_reg       <= RST_VAL_8;
        end
        else if (reg_we)
        begin
            case (reg_addr)
                ADDR_RDIV_LOW:  rdiv_low_reg  <= reg_wdata;
                ADDR_RDIV_HIGH: rdiv_high_reg <= {2'b00, reg_wdata[5:0]};
                ADDR_BIAS_CTRL: bias_reg      <= reg_wdata;
                ADDR_MON_CTRL:  mon_reg       <= {4'h0, reg_wdata[3:0]};
                ADDR_SEL_CTRL:  sel_reg       <= reg_wdata;
                default:        ;
            endcase
        end
    end

    // ********************************
    // input enables and power-down
    // ********************************
    logic diff_mode;
    logic first_on;
    logic second_on;
    assign diff_mode = sel_reg[SEL_DIFF];
    // differential uses the first pin pair; it needs the first enable bit too
    assign first_on  = sel_reg[SEL_FIRST_ON] && !pll_power_down;
    assign second_on = sel_reg[SEL_SECOND_ON] && !pll_power_down
                       && !diff_mode;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            diff_rx_pd    <= 1'b1;
            first_ref_pd  <= 1'b1;
            second_ref_pd <= 1'b1;
        end
        else
        begin
            diff_rx_pd    <= !(diff_mode && first_on);
            first_ref_pd  <= !first_on || diff_mode;
            second_ref_pd <= !second_on;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dc_offset_en       <= 1'b0;
            crystal_amp_enable <= 1'b0;
        end
        else
        begin
            dc_offset_en       <= bias_reg[BIAS_DC_OFFSET];
            crystal_amp_enable <= bias_reg[BIAS_XTAL_EN];
        end
    end

    // ********************************
    // edge detect and loss monitor
    // ********************************
    logic       first_d_reg;
    logic       second_d_reg;
    logic       first_edge;
    logic       second_edge;
    logic [7:0] first_idle_reg;
    logic [7:0] second_idle_reg;
    logic       first_bad;
    logic       second_bad;

    assign first_edge  = first_on && first_reference && !first_d_reg;
    assign second_edge = second_on && second_reference && !second_d_reg;
    assign first_bad   = (first_idle_reg >= REF_TIMEOUT_CYC);
    assign second_bad  = (second_idle_reg >= REF_TIMEOUT_CYC);

    // counter saturates so a long outage never wraps back to valid
    function automatic logic [7:0] idle_next(input logic [7:0] cnt,
                                             input logic edge_seen);
        if (edge_seen)
            idle_next = 8'h00;
        else if (cnt >= REF_TIMEOUT_CYC)
            idle_next = cnt;
        else
            idle_next = cnt + 8'h01;
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            first_d_reg     <= 1'b0;
            second_d_reg    <= 1'b0;
            first_idle_reg  <= REF_TIMEOUT_CYC;
            second_idle_reg <= REF_TIMEOUT_CYC;
        end
        else
        begin
            first_d_reg     <= first_reference;
            second_d_reg    <= second_reference;
            first_idle_reg  <= idle_next(first_idle_reg, first_edge);
            second_idle_reg <= idle_next(second_idle_reg, second_edge);
        end
    end

    logic mon_next;
    always_comb
    begin
        case (mon_reg[MON_SRC_LSB +: 3])
            MON_FIRST_BAD:  mon_next = first_bad;
            MON_SECOND_BAD: mon_next = second_bad;
            MON_HIGH:       mon_next = 1'b1;
            default:        mon_next = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ref_loss_monitor_out <= 1'b0;
        else
            ref_loss_monitor_out <= mon_next;
    end

    // ********************************
    // switchover choice
    // ********************************
    logic switch_cmd;
    logic want_second;
    assign switch_cmd = mon_reg[MON_USE_STATUS] ? status_in
                                                : ref_loss_monitor_out;
    always_comb
    begin
        if (diff_mode)
            want_second = 1'b0;
        else if (sel_reg[SEL_AUTO])
            // revertive only: command released means preferred again
            want_second = sel_reg[SEL_PREF_SEC] ? !switch_cmd
                                                : switch_cmd;
        else if (sel_reg[SEL_USE_PIN])
            want_second = ref_choose_pin;
        else
            want_second = sel_reg[SEL_MAN_SECOND];
    end

    // ********************************
    // deglitch
    // ********************************
    prsd_dg_t dg_reg;
    logic     sel_edge;
    logic     target_edge;
    assign target_edge = want_second ? second_edge : first_edge;
    assign sel_edge    = second_active ? second_edge : first_edge;

    // without a clock on the target the wait ends only when want_second reverts or differential is chosen: software's duty
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dg_reg        <= DG_PASS;
            second_active <= 1'b0;
        end
        else if (diff_mode)
        begin
            // differential owns the first pin pair; no wait for an edge
            dg_reg        <= DG_PASS;
            second_active <= 1'b0;
        end
        else
        begin
            case (dg_reg)
                DG_PASS:
                    if (want_second != second_active)
                    begin
                        if (sel_reg[SEL_DEGL_DIS])
                            second_active <= want_second;
                        else
                            dg_reg <= DG_WAIT;
                    end
                DG_WAIT:
                    if (want_second == second_active)
                        dg_reg <= DG_PASS;
                    else if (target_edge)
                    begin
                        second_active <= want_second;
                        dg_reg        <= DG_PASS;
                    end
                default:
                    dg_reg <= DG_PASS;
            endcase
        end
    end

    logic ref_edge;
    assign ref_edge = (dg_reg == DG_PASS) && sel_edge;

    // ********************************
    // reference divider
    // ********************************
    logic [RDIV_W-1:0] ratio;
    logic [RDIV_W-1:0] rcnt_reg;
    logic              rdiv_clr;
    assign ratio    = {rdiv_high_reg[5:0], rdiv_low_reg};
    assign rdiv_clr = bias_reg[BIAS_R_RESET] || bias_reg[BIAS_SHARE_RST]
                      || sync_pulse;

    always_ff @(posedge ref_clk)
    begin
        if (rst || rdiv_clr)
        begin
            rcnt_reg    <= '0;
            pfd_ref_out <= 1'b0;
        end
        else if (ref_edge)
        begin
            // zero and one both terminate on every edge
            if (ratio <= 14'h0001 || rcnt_reg >= ratio - 14'h0001)
            begin
                rcnt_reg    <= '0;
                pfd_ref_out <= 1'b1;
            end
            else
            begin
                rcnt_reg    <= rcnt_reg + 14'h0001;
                pfd_ref_out <= 1'b0;
            end
        end
        else
            pfd_ref_out <= 1'b0;
    end

    // ********************************
    // read back
    // ********************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            reg_rdata <= RST_VAL_8;
        else if (reg_re)
        begin
            case (reg_addr)
                ADDR_RDIV_LOW:  reg_rdata <= rdiv_low_reg;
                ADDR_RDIV_HIGH: reg_rdata <= rdiv_high_reg;
                ADDR_BIAS_CTRL: reg_rdata <= bias_reg;
                ADDR_MON_CTRL:  reg_rdata <= {dg_reg == DG_WAIT,
                                    second_active, second_bad, first_bad,
                                    mon_reg[3:0]};
                ADDR_SEL_CTRL:  reg_rdata <= sel_reg;
                default:        reg_rdata <= RST_VAL_8;
            endcase
        end
    end

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_diff_forces_se_off;
        diff_mode |=> first_ref_pd && second_ref_pd;
    endproperty
    a_diff_forces_se_off: assert property (p_diff_forces_se_off)
        else $error("single-ended buffer on in differential mode");

    property p_pll_pd_all_off;
        pll_power_down |=> diff_rx_pd && first_ref_pd && second_ref_pd;
    endproperty
    a_pll_pd_all_off: assert property (p_pll_pd_all_off)
        else $error("input powered while pll powered down");

    property p_diff_no_switch;
        diff_mode && $past(diff_mode) |-> !second_active;
    endproperty
    a_diff_no_switch: assert property (p_diff_no_switch)
        else $error("second reference active in differential mode");

    property p_monitor_first_bad;
        mon_reg[2:0] == MON_FIRST_BAD && first_bad |=> ref_loss_monitor_out;
    endproperty
    a_monitor_first_bad: assert property (p_monitor_first_bad)
        else $error("monitor low while first reference invalid");

    property p_nodegl_switch;
        dg_reg == DG_PASS && sel_reg[SEL_DEGL_DIS]
            && want_second != second_active |=> second_active == $past(want_second);
    endproperty
    a_nodegl_switch: assert property (p_nodegl_switch)
        else $error("switch without deglitch not immediate");

    property p_wait_blocks;
        dg_reg == DG_WAIT |-> !ref_edge;
    endproperty
    a_wait_blocks: assert property (p_wait_blocks)
        else $error("edge passed during deglitch wait");

    property p_div_one;
        ratio <= 14'h0001 && ref_edge && !rdiv_clr |=> pfd_ref_out;
    endproperty
    a_div_one: assert property (p_div_one)
        else $error("ratio zero or one did not pass edge");

    property p_reset_holds;
        rdiv_clr |=> !pfd_ref_out && rcnt_reg == '0;
    endproperty
    a_reset_holds: assert property (p_reset_holds)
        else $error("divider ran while reset held");

    c_switch_second: cover property (!second_active ##1 second_active);
    c_revert_first:  cover property (second_active ##1 !second_active);
    c_div_out:       cover property (pfd_ref_out && ratio > 14'h0002);
endmodule
`default_nettype wire

// *** bench/prsd_ref_src.sv ***
/*
 * reference source model: two single-ended clocks built from ref_clk.
 * assumes the block samples its references on ref_clk rising edges.
 */
`timescale 1ns/100ps
`default_nettype none
module prsd_ref_src
#(
    parameter int HALF_FIRST  = 2,
    parameter int HALF_SECOND = 3
)
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // run controls
    input  wire logic first_run,
    input  wire logic second_run,
    // reference levels
    output logic      first_reference,
    output logic      second_reference
);
    // ********************************
    // toggling sources
    // ********************************
    int cnt_first;
    int cnt_second;
    // a stopped source parks low, as a lost cmos reference would
    always @(posedge ref_clk)
    begin
        if (rst || !first_run)
        begin
            cnt_first       <= 0;
            first_reference <= 1'b0;
        end
        else if (cnt_first == HALF_FIRST - 1)
        begin
            cnt_first       <= 0;
            first_reference <= !first_reference;
        end
        else
            cnt_first <= cnt_first + 1;
    end
    always @(posedge ref_clk)
    begin
        if (rst || !second_run)
        begin
            cnt_second       <= 0;
            second_reference <= 1'b0;
        end
        else if (cnt_second == HALF_SECOND - 1)
        begin
            cnt_second       <= 0;
            second_reference <= !second_reference;
        end
        else
            cnt_second <= cnt_second + 1;
    end
endmodule
`default_nettype wire

// *** bench/tb_prsd_ref_path.sv ***
/*
 * self-checking bench for the reference select and divide block.
 * assumes the source model in prsd_ref_src and a 50 MHz ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_prsd_ref_path import prsd_pkg::*;;
    // ********************************
    // signals
    // ********************************
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic [9:0] reg_addr = 10'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_we = 1'b0;
    logic       reg_re = 1'b0;
    logic [7:0] reg_rdata;
    logic       first_reference, second_reference;
    logic       first_run = 1'b0, second_run = 1'b0;
    logic       ref_choose_pin = 1'b0, status_in = 1'b0;
    logic       pll_power_down = 1'b0, sync_pulse = 1'b0;
    logic       diff_rx_pd, first_ref_pd, second_ref_pd;
    logic       dc_offset_en, crystal_amp_enable;
    logic       ref_loss_monitor_out, second_active, pfd_ref_out;
    logic       first_prev = 1'b0;
    int         failures = 0, compares = 0, edges = 0, pulses = 0;
    logic [7:0] q, d;
    logic [2:0] e;
    logic [9:0] addrs [5] = '{ADDR_RDIV_LOW, ADDR_RDIV_HIGH,
        ADDR_BIAS_CTRL, ADDR_MON_CTRL, ADDR_SEL_CTRL};
    logic [7:0] masks [5] = '{8'hff, 8'h3f, 8'hff, 8'h0f, 8'hff};
    int         rvals [6];

    always #10 ref_clk = !ref_clk;

    prsd_ref_path prsd_ref_path_inst (.ref_clk(ref_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata),
        .first_reference(first_reference),
        .second_reference(second_reference),
        .ref_choose_pin(ref_choose_pin), .status_in(status_in),
        .pll_power_down(pll_power_down), .sync_pulse(sync_pulse),
        .diff_rx_pd(diff_rx_pd), .first_ref_pd(first_ref_pd),
        .second_ref_pd(second_ref_pd), .dc_offset_en(dc_offset_en),
        .crystal_amp_enable(crystal_amp_enable),
        .ref_loss_monitor_out(ref_loss_monitor_out),
        .second_active(second_active), .pfd_ref_out(pfd_ref_out));
    prsd_ref_src prsd_ref_src_inst (.ref_clk(ref_clk), .rst(rst),
        .first_run(first_run), .second_run(second_run),
        .first_reference(first_reference),
        .second_reference(second_reference));

    // bench-side edge and pulse tally, sampled as the block samples
    always @(posedge ref_clk)
    begin
        if (first_reference === 1'b1 && first_prev === 1'b0)
            edges++;
        first_prev <= first_reference;
        if (pfd_ref_out === 1'b1)
            pulses++;
    end

    // ********************************
    // tasks
    // ********************************
    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_we    <= 1'b1;
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge ref_clk);
        reg_re <= 1'b0;
        @(posedge ref_clk);
        #1 v = reg_rdata;
    endtask
    task automatic check_bit(input string n, input logic x, input logic g);
        compares++;
        if (g !== x)
        begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", n, x, g);
        end
    endtask
    task automatic check_byte(input string n, input logic [7:0] x,
                              input logic [7:0] g);
        compares++;
        if (g !== x)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic check_count(input string n, input int x, input int g);
        compares++;
        if (g != x)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", n, x, g);
        end
    endtask
    // which: 0 monitor, 1 second_active; bounded wait then compare
    task automatic wait_for(input int w, input logic v, input int n,
                            input string name);
        logic g;
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            #1 g = w ? second_active : ref_loss_monitor_out;
            if (g === v)
                break;
        end
        check_bit(name, v, g);
    endtask
    // expected power-downs {diff, first, second}
    function automatic logic [2:0] exp_pd(input logic [2:0] s,
                                          input logic pd);
        return {pd | !s[0] | !s[1], pd | s[0] | !s[1], pd | s[0] | !s[2]};
    endfunction
    function automatic int exp_pulses(input int n, input int r);
        return n / ((r <= 1) ? 1 : r);
    endfunction
    // leftover count first, so a clear that fails shows in the tally
    task automatic div_run(input int r, input int kind);
        wr(ADDR_RDIV_LOW, r[7:0]);
        wr(ADDR_RDIV_HIGH, {2'b00, r[13:8]});
        first_run <= 1'b1;
        repeat (30) @(posedge ref_clk);
        first_run <= 1'b0;
        repeat (4) @(posedge ref_clk);
        if (kind == 2)
        begin
            sync_pulse <= 1'b1;
            @(posedge ref_clk);
            sync_pulse <= 1'b0;
        end
        else
        begin
            wr(ADDR_BIAS_CTRL, (kind == 0) ? 8'h01 : 8'h02);
            wr(ADDR_BIAS_CTRL, 8'h00);
        end
        repeat (2) @(posedge ref_clk);
        #1 edges = 0;
        pulses = 0;
        first_run <= 1'b1;
        repeat ((((r <= 1) ? 1 : r) * 3 + 1) * 4) @(posedge ref_clk);
        first_run <= 1'b0;
        repeat (5) @(posedge ref_clk);
        check_count("pfd pulses", exp_pulses(edges, r), pulses);
    endtask
    task automatic summarize;
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ********************************
    // sequence
    // ********************************
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        summarize;
    end
    initial
    begin
        void'($urandom(32'h0000_0b3d));
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            rd(addrs[k], q);
            check_byte("reset value", 8'h00, q & masks[k]);
        end
        check_bit("first pd at reset", 1'b1, first_ref_pd);
        check_bit("diff pd at reset", 1'b1, diff_rx_pd);
        for (int k = 0; k < 5; k++)
        begin
            d = 8'($urandom);
            wr(addrs[k], d);
            rd(addrs[k], q);
            check_byte("readback", d & masks[k], q & masks[k]);
        end
        wr(10'h013, 8'h5a);
        rd(10'h013, q);
        check_byte("unmapped", 8'h00, q);
        for (int k = 0; k < 16; k++)
        begin
            wr(ADDR_SEL_CTRL, {5'h00, 3'(k)});
            wr(ADDR_BIAS_CTRL, {k[1], k[0], 6'h00});
            pll_power_down <= k[3];
            repeat (3) @(posedge ref_clk);
            #1 e = exp_pd(3'(k), k[3]);
            check_bit("diff pd", e[2], diff_rx_pd);
            check_bit("first pd", e[1], first_ref_pd);
            check_bit("second pd", e[0], second_ref_pd);
            check_bit("dc offset", k[1], dc_offset_en);
            check_bit("crystal amp", k[0], crystal_amp_enable);
        end
        pll_power_down <= 1'b0;
        wr(ADDR_SEL_CTRL, 8'h02);
        rvals = '{0, 1, 2, 5, 259, 3 + ($urandom % 38)};
        for (int i = 0; i < 6; i++)
            div_run(rvals[i], i % 3);
        first_run <= 1'b1;
        second_run <= 1'b1;
        wr(ADDR_MON_CTRL, 8'hf7);
        wr(ADDR_SEL_CTRL, 8'h26);
        wait_for(0, 1'b0, 120, "monitor idle");
        wait_for(1, 1'b0, 20, "first in use");
        first_run <= 1'b0;
        wait_for(0, 1'b1, 80, "monitor on loss");
        wait_for(1, 1'b1, 20, "switch to second");
        first_run <= 1'b1;
        wait_for(0, 1'b0, 20, "monitor recovers");
        wait_for(1, 1'b0, 20, "revert to first");
        wr(ADDR_MON_CTRL, 8'hf6);
        wr(ADDR_SEL_CTRL, 8'h66);
        wait_for(1, 1'b1, 80, "preferred second");
        second_run <= 1'b0;
        wait_for(1, 1'b0, 80, "second lost");
        second_run <= 1'b1;
        wait_for(1, 1'b1, 80, "revert to second");
        wr(ADDR_MON_CTRL, 8'h0f);
        wr(ADDR_SEL_CTRL, 8'h26);
        wait_for(1, 1'b0, 20, "status low");
        status_in <= 1'b1;
        wait_for(1, 1'b1, 20, "status high");
        status_in <= 1'b0;
        wr(ADDR_SEL_CTRL, 8'h06);
        wait_for(1, 1'b0, 20, "manual first");
        wr(ADDR_SEL_CTRL, 8'h0e);
        wait_for(1, 1'b1, 20, "manual second");
        wr(ADDR_SEL_CTRL, 8'h16);
        wait_for(1, 1'b0, 20, "pin low");
        ref_choose_pin <= 1'b1;
        wait_for(1, 1'b1, 20, "pin high");
        ref_choose_pin <= 1'b0;
        wait_for(1, 1'b0, 20, "pin back");
        second_run <= 1'b0;
        wr(ADDR_SEL_CTRL, 8'h0e);
        repeat (20) @(posedge ref_clk);
        #1 check_bit("deglitch hold", 1'b0, second_active);
        second_run <= 1'b1;
        wait_for(1, 1'b1, 20, "deglitch release");
        first_run <= 1'b0;
        wr(ADDR_SEL_CTRL, 8'h86);
        wait_for(1, 1'b0, 3, "no deglitch");
        first_run <= 1'b1;
        wr(ADDR_SEL_CTRL, 8'h8e);
        wait_for(1, 1'b1, 3, "second again");
        wr(ADDR_SEL_CTRL, 8'h0b);
        wait_for(1, 1'b0, 20, "diff uses first");
        check_bit("diff first pd", 1'b1, first_ref_pd);
        check_bit("diff second pd", 1'b1, second_ref_pd);
        summarize;
    end
endmodule
`default_nettype wire
